// ---- opfd_pkg.sv ----
// opfd_pkg: field layouts, encodings and enums for the operand field decoder
// assumes: used by opfd_top and opfd_addr_if
package opfd_pkg;
   localparam int MODE_HI = 7;
   localparam int MODE_LO = 6;
   localparam int REG_HI  = 5;
   localparam int REG_LO  = 3;
   localparam int RM_HI   = 2;
   localparam int RM_LO   = 0;
   localparam int SS_HI   = 7;
   localparam int SS_LO   = 6;
   localparam int IDX_HI  = 5;
   localparam int IDX_LO  = 3;
   localparam int BASE_HI = 2;
   localparam int BASE_LO = 0;

   localparam logic [1:0] MODE_NODISP = 2'h0;
   localparam logic [1:0] MODE_DISP8  = 2'h1;
   localparam logic [1:0] MODE_DISP32 = 2'h2;
   localparam logic [1:0] MODE_REG    = 2'h3;
   localparam logic [2:0] RM_SIB      = 3'h4;
   localparam logic [2:0] RM_FRAME    = 3'h5;
   localparam logic [2:0] BASE_STACK  = 3'h4;
   localparam logic [2:0] BASE_FRAME  = 3'h5;
   localparam logic [2:0] IDX_NONE    = 3'h4;
   localparam logic [1:0] SS_ONE      = 2'h0;

   // general register numbers
   localparam logic [2:0] GPR_ACCUM_32     = 3'h0;
   localparam logic [2:0] GPR_STACK_PTR_32 = 3'h4;
   localparam logic [2:0] GPR_FRAME_PTR_32 = 3'h5;

   // special register codes
   localparam logic [2:0] SPR_CODE_0 = 3'h0;
   localparam logic [2:0] SPR_CODE_1 = 3'h1;
   localparam logic [2:0] SPR_CODE_2 = 3'h2;
   localparam logic [2:0] SPR_CODE_3 = 3'h3;
   localparam logic [2:0] SPR_CODE_6 = 3'h6;
   localparam logic [2:0] SPR_CODE_7 = 3'h7;

   localparam int DISP8_W  = 8;
   localparam int DISP32_W = 32;

   typedef enum logic [1:0] {
      OPFD_SEG_DATA,
      OPFD_SEG_STACK
   } opfd_seg_e;

   typedef enum logic [1:0] {
      OPFD_DISP_NONE,
      OPFD_DISP_BYTE,
      OPFD_DISP_DWORD
   } opfd_disp_e;

   typedef enum logic [1:0] {
      OPFD_WIDTH_8,
      OPFD_WIDTH_16,
      OPFD_WIDTH_32
   } opfd_width_e;

   typedef enum logic [1:0] {
      OPFD_SPR_CONTROL,
      OPFD_SPR_DEBUG,
      OPFD_SPR_TEST
   } opfd_spr_e;

   typedef enum logic [2:0] {
      OPFD_COND_OVERFLOW,
      OPFD_COND_BELOW,
      OPFD_COND_EQUAL,
      OPFD_COND_BELOW_EQUAL,
      OPFD_COND_SIGN,
      OPFD_COND_PARITY,
      OPFD_COND_LESS,
      OPFD_COND_LESS_EQUAL
   } opfd_cond_e;
endpackage

// ---- opfd_addr_if.sv ----
// opfd_addr_if: carries the decoded address plan from decoder to adder
// assumes: both ends sit inside opfd_top
`timescale 1ns/100ps
interface opfd_addr_if;
   import opfd_pkg::*;
   logic        base_en;
   logic [31:0] base_val;
   logic        index_en;
   logic [31:0] index_val;
   logic [1:0]  scale;
   opfd_disp_e  disp_kind;
   logic [31:0] disp_raw;
   logic [31:0] eff_addr;
   modport decoder (output base_en, base_val, index_en, index_val, scale, disp_kind,
                    disp_raw, input eff_addr);
   modport adder (input base_en, base_val, index_en, index_val, scale, disp_kind,
                  disp_raw, output eff_addr);
endinterface

// ---- opfd_ea_adder.sv ----
// opfd_ea_adder: combinational effective-address sum of base, scaled index, displacement
// assumes: fields settled by the decoder in the same cycle
`timescale 1ns/100ps
module opfd_ea_adder
   import opfd_pkg::*;
(
   opfd_addr_if.adder a
);
   logic [31:0] scaled;
   logic [31:0] disp_ext;

   always_comb begin
      scaled = a.index_en ? (a.index_val << a.scale) : 32'h0;
      unique case (a.disp_kind)
         OPFD_DISP_BYTE:  disp_ext = {{24{a.disp_raw[DISP8_W-1]}}, a.disp_raw[DISP8_W-1:0]};
         OPFD_DISP_DWORD: disp_ext = a.disp_raw;
         default:         disp_ext = 32'h0;
      endcase
      a.eff_addr = (a.base_en ? a.base_val : 32'h0) + scaled + disp_ext;
   end
endmodule

// ---- opfd_top.sv ----
// opfd_top: operand field decoder, registers the decoded result each clock
// assumes: prefetch path presents instruction bytes and register file values synchronously
`timescale 1ns/100ps
module opfd_top
   import opfd_pkg::*;
#(
   parameter int DATA_W = 32
) (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic [7:0]  modrm_byte,
   input  wire logic [7:0]  sib_byte,
   input  wire logic [31:0] disp_in,
   input  wire logic        addr32,
   input  wire logic        data32,
   input  wire logic        width_bit,
   input  wire logic        dir_bit,
   input  wire logic        sext_bit,
   input  wire logic        imm_is_byte,
   input  wire logic [31:0] imm_in,
   input  wire logic [3:0]  cond_code,
   input  wire logic [DATA_W*8-1:0] gpr_vals,
   input  wire logic [4:0]  flags_in,
   input  wire opfd_spr_e   spr_kind,
   output logic             sib_used,
   output logic             is_reg_operand,
   output opfd_seg_e        seg_sel,
   output opfd_disp_e       disp_sel,
   output logic [31:0]      eff_addr,
   output logic [2:0]       rm_reg_num,
   output opfd_width_e      rm_reg_width,
   output logic             rm_reg_high_byte,
   output logic [2:0]       reg_reg_num,
   output opfd_width_e      reg_reg_width,
   output logic             reg_reg_high_byte,
   output logic             reg_is_dest,
   output logic [31:0]      imm_out,
   output opfd_cond_e       cond_sel,
   output logic             cond_true,
   output logic [2:0]       spr_num,
   output logic             spr_invalid
);
   // flags_in order: [0] carry [1] zero [2] sign [3] overflow [4] parity
   opfd_addr_if ai ();

   opfd_ea_adder u_add (
      .a (ai.adder)
   );

   logic [1:0]  mode;
   logic [2:0]  rm, regf, ss, idx, base;
   logic        sib_d, isreg_d, hb_rm_d, hb_reg_d, dest_d, cond_d, sprinv_d;
   opfd_seg_e   seg_d;
   opfd_disp_e  disp_d;
   opfd_width_e w_d;
   logic [31:0] imm_d;
   logic [2:0]  rmnum_d, regnum_d, sprn_d;
   logic        cbase;

   logic        sib_q, isreg_q, hb_rm_q, hb_reg_q, dest_q, cond_q, sprinv_q;
   opfd_seg_e   seg_q;
   opfd_disp_e  disp_q;
   opfd_width_e w_q;
   logic [31:0] ea_q, imm_q;
   logic [2:0]  rmnum_q, regnum_q, sprn_q;
   opfd_cond_e  csel_q, csel_d;

   function automatic logic [31:0] gpr(input logic [2:0] n);
      gpr = gpr_vals[n*DATA_W +: 32];
   endfunction

   always_comb begin
      mode = modrm_byte[MODE_HI:MODE_LO];
      regf = modrm_byte[REG_HI:REG_LO];
      rm   = modrm_byte[RM_HI:RM_LO];
      ss   = {1'b0, sib_byte[SS_HI:SS_LO]};
      idx  = sib_byte[IDX_HI:IDX_LO];
      base = sib_byte[BASE_HI:BASE_LO];

      isreg_d = (mode == MODE_REG);
      sib_d   = addr32 && !isreg_d && (rm == RM_SIB);
      seg_d   = OPFD_SEG_DATA;
      disp_d  = OPFD_DISP_NONE;
      ai.base_en   = 1'b1;
      ai.base_val  = gpr(rm);
      ai.index_en  = 1'b0;
      ai.index_val = 32'h0;
      ai.scale     = 2'h0;
      ai.disp_raw  = disp_in;

      if (!isreg_d) begin
         if (mode == MODE_DISP8) begin
            disp_d = OPFD_DISP_BYTE;
         end else if (mode == MODE_DISP32) begin
            disp_d = OPFD_DISP_DWORD;
         end
         if (sib_d) begin
            ai.base_val  = gpr(base);
            ai.index_en  = (idx != IDX_NONE);
            ai.index_val = gpr(idx);
            ai.scale     = ss[1:0];
            if (base == BASE_STACK) begin
               seg_d = OPFD_SEG_STACK;
            end else if (base == BASE_FRAME) begin
               if (mode == MODE_NODISP) begin
                  ai.base_en = 1'b0;
                  disp_d     = OPFD_DISP_DWORD;
               end else begin
                  seg_d = OPFD_SEG_STACK;
               end
            end
         end else if (rm == RM_FRAME) begin
            if (mode == MODE_NODISP) begin
               ai.base_en = 1'b0;
               disp_d     = OPFD_DISP_DWORD;
            end else begin
               seg_d = OPFD_SEG_STACK;
            end
         end
      end

      // register operands by width bit
      w_d = !width_bit ? OPFD_WIDTH_8 : (data32 ? OPFD_WIDTH_32 : OPFD_WIDTH_16);
      rmnum_d  = width_bit ? rm : {1'b0, rm[1:0]};
      regnum_d = width_bit ? regf : {1'b0, regf[1:0]};
      hb_rm_d  = !width_bit && rm[2];
      hb_reg_d = !width_bit && regf[2];
      dest_d   = dir_bit;

      // immediate
      if (sext_bit && imm_is_byte && width_bit) begin
         imm_d = {{24{imm_in[DISP8_W-1]}}, imm_in[DISP8_W-1:0]};
      end else if (imm_is_byte) begin
         imm_d = {24'h0, imm_in[DISP8_W-1:0]};
      end else begin
         imm_d = imm_in;
      end
      if (!data32 && width_bit && !imm_is_byte) begin
         imm_d = {16'h0, imm_in[15:0]};
      end

      // conditional test
      csel_d = opfd_cond_e'(cond_code[3:1]);
      unique case (csel_d)
         OPFD_COND_OVERFLOW:    cbase = flags_in[3];
         OPFD_COND_BELOW:       cbase = flags_in[0];
         OPFD_COND_EQUAL:       cbase = flags_in[1];
         OPFD_COND_BELOW_EQUAL: cbase = flags_in[0] | flags_in[1];
         OPFD_COND_SIGN:        cbase = flags_in[2];
         OPFD_COND_PARITY:      cbase = flags_in[4];
         OPFD_COND_LESS:        cbase = flags_in[2] ^ flags_in[3];
         OPFD_COND_LESS_EQUAL:  cbase = (flags_in[2] ^ flags_in[3]) | flags_in[1];
      endcase
      cond_d = cbase ^ cond_code[0];

      // special register selector
      sprn_d = regf;
      unique case (spr_kind)
         OPFD_SPR_CONTROL: sprinv_d = !(regf == SPR_CODE_0 || regf == SPR_CODE_2 ||
                                        regf == SPR_CODE_3);
         OPFD_SPR_DEBUG:   sprinv_d = !(regf <= SPR_CODE_3 || regf == SPR_CODE_6 ||
                                        regf == SPR_CODE_7);
         OPFD_SPR_TEST:    sprinv_d = !(regf == SPR_CODE_6 || regf == SPR_CODE_7);
         default:          sprinv_d = 1'b1;
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sib_q    <= 1'b0;
         isreg_q  <= 1'b0;
         seg_q    <= OPFD_SEG_DATA;
         disp_q   <= OPFD_DISP_NONE;
         ea_q     <= 32'h0;
         rmnum_q  <= 3'h0;
         regnum_q <= 3'h0;
         w_q      <= OPFD_WIDTH_8;
         hb_rm_q  <= 1'b0;
         hb_reg_q <= 1'b0;
         dest_q   <= 1'b0;
         imm_q    <= 32'h0;
         csel_q   <= OPFD_COND_OVERFLOW;
         cond_q   <= 1'b0;
         sprn_q   <= 3'h0;
         sprinv_q <= 1'b0;
      end else begin
         sib_q    <= sib_d;
         isreg_q  <= isreg_d;
         seg_q    <= seg_d;
         disp_q   <= disp_d;
         ea_q     <= ai.eff_addr;
         rmnum_q  <= rmnum_d;
         regnum_q <= regnum_d;
         w_q      <= w_d;
         hb_rm_q  <= hb_rm_d;
         hb_reg_q <= hb_reg_d;
         dest_q   <= dest_d;
         imm_q    <= imm_d;
         csel_q   <= csel_d;
         cond_q   <= cond_d;
         sprn_q   <= sprn_d;
         sprinv_q <= sprinv_d;
      end
   end

   always_comb begin
      ai.disp_kind = disp_d;
   end

   assign sib_used          = sib_q;
   assign is_reg_operand    = isreg_q;
   assign seg_sel           = seg_q;
   assign disp_sel          = disp_q;
   assign eff_addr          = ea_q;
   assign rm_reg_num        = rmnum_q;
   assign rm_reg_width      = w_q;
   assign rm_reg_high_byte  = hb_rm_q;
   assign reg_reg_num       = regnum_q;
   assign reg_reg_width     = w_q;
   assign reg_reg_high_byte = hb_reg_q;
   assign reg_is_dest       = dest_q;
   assign imm_out           = imm_q;
   assign cond_sel          = csel_q;
   assign cond_true         = cond_q;
   assign spr_num           = sprn_q;
   assign spr_invalid       = sprinv_q;
endmodule

// ---- opfd_checker_asserts.sv ----
// opfd_checker: port-level timing and decode checks for opfd_top
// assumes: bound to opfd_top; outputs follow inputs by one clock
`timescale 1ns/100ps
module opfd_checker
   import opfd_pkg::*;
(
   input wire logic        clk,
   input wire logic        reset,
   input wire logic [7:0]  modrm_byte,
   input wire logic [31:0] disp_in,
   input wire logic        addr32,
   input wire logic        dir_bit,
   input wire logic [3:0]  cond_code,
   input wire opfd_spr_e   spr_kind,
   input wire logic        sib_used,
   input wire logic        is_reg_operand,
   input wire opfd_seg_e   seg_sel,
   input wire logic [31:0] eff_addr,
   input wire logic        reg_is_dest,
   input wire opfd_cond_e  cond_sel,
   input wire logic        spr_invalid
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   a_reg_operand: assert property (!$past(reset) |->
      is_reg_operand == ($past(modrm_byte[7:6]) == MODE_REG)) else $error("reg operand flag");
   a_sib_pull: assert property (!$past(reset) |-> sib_used == ($past(addr32) &&
      $past(modrm_byte[7:6]) != MODE_REG && $past(modrm_byte[2:0]) == RM_SIB))
      else $error("sib use flag");
   a_dir_route: assert property (!$past(reset) |-> reg_is_dest == $past(dir_bit))
      else $error("direction routing");
   a_cond_select: assert property (!$past(reset) |-> cond_sel == $past(cond_code[3:1]))
      else $error("condition select");
   a_ctrl_codes: assert property (!$past(reset) && $past(spr_kind) == OPFD_SPR_CONTROL |->
      spr_invalid == !($past(modrm_byte[5:3]) inside {3'h0, 3'h2, 3'h3}))
      else $error("control code check");
   a_debug_codes: assert property (!$past(reset) && $past(spr_kind) == OPFD_SPR_DEBUG |->
      spr_invalid == ($past(modrm_byte[5:3]) inside {3'h4, 3'h5})) else $error("debug code check");
   a_test_codes: assert property (!$past(reset) && $past(spr_kind) == OPFD_SPR_TEST |->
      spr_invalid == ($past(modrm_byte[5:3]) < 3'h6)) else $error("test code check");
   a_bare_disp: assert property (!$past(reset) && $past(modrm_byte[7:6]) == MODE_NODISP &&
      $past(modrm_byte[2:0]) == RM_FRAME |-> eff_addr == $past(disp_in) &&
      seg_sel == OPFD_SEG_DATA) else $error("bare displacement");
endmodule

// ---- opfd_fetch_model.sv ----
// opfd_fetch_model: prefetch queue stand-in presenting the scale-index byte
// assumes: raw byte comes from the bench, output feeds opfd_top
`timescale 1ns/100ps
module opfd_fetch_model
   import opfd_pkg::*;
(
   input  wire logic [7:0] raw_sib,
   output logic      [7:0] sib_byte
);
   // no-index byte always carries unit scale
   always_comb begin
      sib_byte = raw_sib;
      if (raw_sib[IDX_HI:IDX_LO] == IDX_NONE) sib_byte[SS_HI:SS_LO] = SS_ONE;
   end
endmodule

// ---- tb_top.sv ----
// tb_top: random and corner stimulus for opfd_top, self-checking
// assumes: opfd_pkg, design, checker and fetch model compiled before
`timescale 1ns/100ps
module tb_top
   import opfd_pkg::*;
;
   logic        clk, reset, addr32, data32, width_bit, dir_bit, sext_bit, imm_is_byte;
   logic        sib_used, is_reg_operand, rm_reg_high_byte, reg_reg_high_byte;
   logic        reg_is_dest, cond_true, spr_invalid;
   logic [7:0]  modrm_byte, raw_sib, sib_byte;
   logic [31:0] disp_in, imm_in, eff_addr, imm_out, r;
   logic [3:0]  cond_code;
   logic [4:0]  flags_in;
   logic [2:0]  rm_reg_num, reg_reg_num, spr_num;
   logic [255:0] gpr_vals;
   opfd_spr_e   spr_kind;
   opfd_seg_e   seg_sel;
   opfd_disp_e  disp_sel;
   opfd_width_e rm_reg_width, reg_reg_width;
   opfd_cond_e  cond_sel;
   int          err_count, checked;
   int          cyc = 0;
   logic [15:0] corner [4] = '{16'h4488, 16'h0425, 16'h84E4, 16'h45FF};

   opfd_fetch_model opfd_fetch_model_i (.raw_sib(raw_sib), .sib_byte(sib_byte));
   opfd_top opfd_top_i (.clk(clk), .reset(reset), .modrm_byte(modrm_byte), .sib_byte(sib_byte),
      .disp_in(disp_in), .addr32(addr32), .data32(data32), .width_bit(width_bit),
      .dir_bit(dir_bit), .sext_bit(sext_bit), .imm_is_byte(imm_is_byte), .imm_in(imm_in),
      .cond_code(cond_code), .gpr_vals(gpr_vals), .flags_in(flags_in), .spr_kind(spr_kind),
      .sib_used(sib_used), .is_reg_operand(is_reg_operand), .seg_sel(seg_sel),
      .disp_sel(disp_sel), .eff_addr(eff_addr), .rm_reg_num(rm_reg_num),
      .rm_reg_width(rm_reg_width), .rm_reg_high_byte(rm_reg_high_byte),
      .reg_reg_num(reg_reg_num), .reg_reg_width(reg_reg_width),
      .reg_reg_high_byte(reg_reg_high_byte), .reg_is_dest(reg_is_dest), .imm_out(imm_out),
      .cond_sel(cond_sel), .cond_true(cond_true), .spr_num(spr_num), .spr_invalid(spr_invalid));

   function automatic logic [31:0] lfsr(logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction

   function automatic logic [31:0] ea(logic [7:0] m, logic [7:0] sb, logic s);
      logic [1:0]  md;
      logic [2:0]  b;
      logic [31:0] x, dv;
      md = m[7:6];
      b = s ? sb[2:0] : m[2:0];
      x = (s && sb[5:3] != 3'h4) ? gpr_vals[sb[5:3]*32 +: 32] << sb[7:6] : 32'h0;
      dv = md == 2'h1 ? {{24{disp_in[7]}}, disp_in[7:0]} : md == 2'h2 ? disp_in : 32'h0;
      return x + dv + ((md == 2'h0 && b == 3'h5) ? disp_in : gpr_vals[b*32 +: 32]);
   endfunction

   function automatic logic cnd(logic [2:0] t, logic [4:0] f);
      logic [7:0] v;
      v = {(f[2] ^ f[3]) | f[1], f[2] ^ f[3], f[4], f[2], f[0] | f[1], f[1], f[0], f[3]};
      return v[t];
   endfunction

   function automatic logic bad(opfd_spr_e k, logic [2:0] c);
      case (k)
         OPFD_SPR_CONTROL: return !(c inside {3'h0, 3'h2, 3'h3});
         OPFD_SPR_DEBUG: return c inside {3'h4, 3'h5};
         OPFD_SPR_TEST: return c < 3'h6;
         default: return 1'b1;
      endcase
   endfunction

   task automatic chk(logic [31:0] seen, logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      if (err_count == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // inputs still hold what the last edge sampled
   task automatic check_all();
      logic [7:0] m;
      logic [1:0] md;
      logic [2:0] b;
      logic       s;
      m = modrm_byte;
      md = m[7:6];
      s = addr32 && md != 2'h3 && m[2:0] == 3'h4;
      b = s ? sib_byte[2:0] : m[2:0];
      chk(sib_used, s);
      chk(is_reg_operand, md == 2'h3);
      if (md != 2'h3 && (s || m[2:0] != 3'h4)) begin
         chk(eff_addr, ea(m, sib_byte, s));
         chk(seg_sel, (b == 3'h4 && s) || (b == 3'h5 && md != 2'h0));
         chk(disp_sel, md == 2'h0 ? 2 * (b == 3'h5) : md);
      end
      if (md == 2'h3) chk(rm_reg_num, width_bit ? m[2:0] : {1'b0, m[1:0]});
      chk(reg_reg_num, width_bit ? m[5:3] : {1'b0, m[4:3]});
      chk(reg_reg_high_byte, !width_bit && m[5]);
      chk(rm_reg_high_byte, !width_bit && m[2]);
      chk(rm_reg_width, !width_bit ? 0 : data32 ? 2 : 1);
      chk(reg_reg_width, !width_bit ? 0 : data32 ? 2 : 1);
      chk(reg_is_dest, dir_bit);
      chk(cond_sel, cond_code[3:1]);
      chk(cond_true, cnd(cond_code[3:1], flags_in) ^ cond_code[0]);
      chk(spr_invalid, bad(spr_kind, m[5:3]));
      if (!bad(spr_kind, m[5:3])) chk(spr_num, m[5:3]);
      if (data32) chk(imm_out, !imm_is_byte ? imm_in : (sext_bit && width_bit) ?
         {{24{imm_in[7]}}, imm_in[7:0]} : {24'h0, imm_in[7:0]});
      else chk(imm_out, imm_is_byte ? ((sext_bit && width_bit) ?
         {{24{imm_in[7]}}, imm_in[7:0]} : {24'h0, imm_in[7:0]}) :
         width_bit ? {16'h0, imm_in[15:0]} : imm_in);
   endtask

   task automatic drive(int i);
      for (int k = 0; k < 8; k++) begin
         r = lfsr(r);
         gpr_vals[k*32 +: 32] = r;
      end
      r = lfsr(r);
      {modrm_byte, raw_sib, cond_code, flags_in, addr32, data32} = r[26:0];
      {width_bit, dir_bit, sext_bit, imm_is_byte} = r[31:28];
      disp_in = lfsr(r);
      imm_in = lfsr(disp_in);
      r = imm_in;
      spr_kind = opfd_spr_e'(disp_in[31:30]);
      if (i < 4) begin
         {modrm_byte, raw_sib} = corner[i];
         addr32 = 1'b1;
         disp_in = 32'hF0;
      end
   endtask

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         err_count++;
         close_out();
      end
   end

   initial begin
      r = 32'h3737CB00;
      err_count = 0;
      checked = 0;
      reset = 1'b1;
      drive(9);
      repeat (5) @(posedge clk);
      @(negedge clk);
      reset = 1'b0;
      for (int i = 0; i < 600; i++) begin
         @(negedge clk);
         check_all();
         drive(i);
      end
      close_out();
   end
endmodule

bind opfd_top opfd_checker opfd_checker_i (.clk(clk), .reset(reset), .modrm_byte(modrm_byte),
   .disp_in(disp_in), .addr32(addr32), .dir_bit(dir_bit), .cond_code(cond_code),
   .spr_kind(spr_kind), .sib_used(sib_used), .is_reg_operand(is_reg_operand),
   .seg_sel(seg_sel), .eff_addr(eff_addr), .reg_is_dest(reg_is_dest), .cond_sel(cond_sel),
   .spr_invalid(spr_invalid));
